// [timer_irq_pkg.sv]
// Shared constants and types for the timer prescaler and flag block
`default_nettype none
package timer_irq_pkg;
	localparam logic [5:0] FLAGS_OFF   = 6'h0B;
	localparam logic [5:0] ENABLES_OFF = 6'h0C;
	localparam logic [5:0] GCTRL_OFF   = 6'h23;

	localparam int CAP_BIT  = 5;
	localparam int CMPB_BIT = 2;
	localparam int CMPA_BIT = 1;
	localparam int OVF_BIT  = 0;
	localparam int TSM_BIT  = 7;
	localparam int PSR_BIT  = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Internal flag vector index
	localparam int F_CAP  = 3;
	localparam int F_CMPB = 2;
	localparam int F_CMPA = 1;
	localparam int F_OVF  = 0;

	localparam int PRESC_W = 10;
	localparam logic [PRESC_W-1:0] DIV8_MASK    = 10'h007;
	localparam logic [PRESC_W-1:0] DIV64_MASK   = 10'h03F;
	localparam logic [PRESC_W-1:0] DIV256_MASK  = 10'h0FF;
	localparam logic [PRESC_W-1:0] DIV1024_MASK = 10'h3FF;

	typedef enum logic [2:0] {
		CS_STOP    = 3'h0,
		CS_DIV1    = 3'h1,
		CS_DIV8    = 3'h2,
		CS_DIV64   = 3'h3,
		CS_DIV256  = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} clock_select_t;

	localparam logic [3:0] WGM_NORMAL  = 4'h0;
	localparam logic [3:0] WGM_CTC_CMP = 4'h4;
	localparam logic [3:0] WGM_PFC_ICR = 4'h8;
	localparam logic [3:0] WGM_PC_ICR  = 4'hA;
	localparam logic [3:0] WGM_CTC_ICR = 4'hC;
	localparam logic [3:0] WGM_FAST_ICR = 4'hE;
	localparam logic [15:0] COUNT_MAX  = 16'hFFFF;

	typedef struct packed {
		logic [15:0] counter_value;
		logic [15:0] compare_a_register;
		logic [15:0] compare_b_register;
		logic [15:0] capture_register;
		logic [3:0]  waveform_mode;
	} timer1_core_t;

	typedef struct packed {
		logic [3:0] flags;
		logic [3:0] enables;
		logic       sync_hold_mode;
		logic       prescaler_reset;
		logic       pend_a;
		logic       pend_b;
		logic [7:0] rdata;
	} flag_state_t;

	typedef struct packed {
		logic [PRESC_W-1:0] count;
	} presc_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_t;
endpackage : timer_irq_pkg
`default_nettype wire

// [prescaler.sv]
// Free-running shared system clock prescaler with four taps
`timescale 1ns/1ps
`default_nettype none
module prescaler (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       prescaler_reset_i,
	output logic      [3:0] taps_o
);
	import timer_irq_pkg::*;

	presc_state_t st_q;
	presc_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		// Held at zero while reset is asserted
		if (prescaler_reset_i)
			st_d.count = '0;
		else
			st_d.count = st_q.count + 10'h001;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Tap fires on the last count of each period; free running so first tick lands in 1..N+1
	assign taps_o[0] = (st_q.count & DIV8_MASK) == DIV8_MASK;
	assign taps_o[1] = (st_q.count & DIV64_MASK) == DIV64_MASK;
	assign taps_o[2] = (st_q.count & DIV256_MASK) == DIV256_MASK;
	assign taps_o[3] = (st_q.count & DIV1024_MASK) == DIV1024_MASK;
endmodule : prescaler
`default_nettype wire

// [ext_clock_sync.sv]
// Synchroniser and edge detector for an external timer clock pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_sync (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic external_timer_pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	import timer_irq_pkg::*;

	sync_state_t st_q;
	sync_state_t st_d;

	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = external_timer_pin_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// Only s2 and s3 are compared; s1 may be metastable
	assign rise_o = st_q.s2 & ~st_q.s3;
	assign fall_o = ~st_q.s2 & st_q.s3;
endmodule : ext_clock_sync
`default_nettype wire

// [timer_prescaler_and_irq_flags.sv]
// Timer prescaler, external clock input and timer1 interrupt flags
// How it works
// - Capture request needs capture enable, global flag and capture flag.
// - Compare-B request needs its enable, global flag and compare-B flag.
// - Compare-A request needs its enable, global flag and compare-A flag.
// - Overflow request needs its enable, global flag and overflow flag.
// - Bits 7:6 and 4:3 of enables and flags ignore writes, read zero.
// - Capture event on the capture pin sets the capture flag.
// - With capture register as top, reaching top sets capture flag instead.
// - Capture flag clears on vector acknowledge or software writing one.
// - Compare-B flag sets one timer tick after counter equals compare B.
// - Compare-A flag sets one timer tick after counter equals compare A.
// - Forced compare strobes never set a compare flag.
// - Compare flags clear on vector acknowledge or writing one.
// - Normal and clear-on-compare modes set overflow on counter wrap.
// - Overflow flag clears on vector acknowledge or writing one.
// - One shared prescaler; codes 1 to 5 give divide 1,8,64,256,1024.
// - First prescaled tick comes 1 to N+1 clocks after enabling.
// - External pin synchronised; codes 7 and 6 tick on rise and fall.
// - External edge reaches the counter 2 to 3 clocks later.
// - Sync hold mode keeps prescaler reset as written; clearing it resumes.
// - Writing prescaler reset resets prescaler; auto clears unless hold mode.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler_and_irq_flags (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_i,
	input  wire logic [5:0]                  addr_i,
	input  wire logic [7:0]                  wdata_i,
	input  wire logic                        we_i,
	input  wire logic                        re_i,
	output logic      [7:0]                  rdata_o,
	input  wire logic [2:0]                  clock_select0_i,
	input  wire logic [2:0]                  clock_select1_i,
	input  wire logic                        external_timer_pin0_i,
	input  wire logic                        external_timer_pin1_i,
	output logic                             timer0_tick_o,
	output logic                             timer1_tick_o,
	input  wire timer_irq_pkg::timer1_core_t core_i,
	input  wire logic                        capture_event_i,
	input  wire logic                        overflow_event_i,
	input  wire logic                        force_compare_a_i,
	input  wire logic                        force_compare_b_i,
	input  wire logic                        global_irq_enable_i,
	input  wire logic [3:0]                  irq_ack_i,
	output logic      [3:0]                  irq_req_o
);
	import timer_irq_pkg::*;

	flag_state_t st_q;
	flag_state_t st_d;
	logic [3:0]  taps;
	logic        rise0;
	logic        fall0;
	logic        rise1;
	logic        fall1;
	logic        halted;
	logic        tick0;
	logic        tick1;
	logic        icr_top;
	logic        ovf_plain;
	logic [3:0]  hw_set;
	logic [3:0]  sw_clr;
	logic [7:0]  flags_byte;
	logic [7:0]  enables_byte;

	function automatic logic sel_tick(input logic [2:0] cs, input logic [3:0] tp,
		input logic rise, input logic fall);
		logic t;
		t = 1'b0;
		unique case (clock_select_t'(cs))
			CS_STOP:     t = 1'b0;
			CS_DIV1:     t = 1'b1;
			CS_DIV8:     t = tp[0];
			CS_DIV64:    t = tp[1];
			CS_DIV256:   t = tp[2];
			CS_DIV1024:  t = tp[3];
			CS_EXT_FALL: t = fall;
			CS_EXT_RISE: t = rise;
		endcase
		return t;
	endfunction : sel_tick

	function automatic logic [7:0] pack_bits(input logic [3:0] v);
		logic [7:0] b;
		b = 8'h00;
		b[CAP_BIT]  = v[F_CAP];
		b[CMPB_BIT] = v[F_CMPB];
		b[CMPA_BIT] = v[F_CMPA];
		b[OVF_BIT]  = v[F_OVF];
		return b;
	endfunction : pack_bits

	function automatic logic [3:0] unpack_bits(input logic [7:0] b);
		return {b[CAP_BIT], b[CMPB_BIT], b[CMPA_BIT], b[OVF_BIT]};
	endfunction : unpack_bits

	prescaler u_prescaler (
		.sys_clk_i         (sys_clk_i),
		.rst_i             (rst_i),
		.prescaler_reset_i (st_q.prescaler_reset),
		.taps_o            (taps)
	);

	ext_clock_sync u_ext0 (
		.sys_clk_i            (sys_clk_i),
		.rst_i                (rst_i),
		.external_timer_pin_i (external_timer_pin0_i),
		.rise_o               (rise0),
		.fall_o               (fall0)
	);

	ext_clock_sync u_ext1 (
		.sys_clk_i            (sys_clk_i),
		.rst_i                (rst_i),
		.external_timer_pin_i (external_timer_pin1_i),
		.rise_o               (rise1),
		.fall_o               (fall1)
	);

	// Held prescaler reset stops every timer, external ones included
	assign halted = st_q.prescaler_reset;
	assign tick0  = ~halted & sel_tick(clock_select0_i, taps, rise0, fall0);
	assign tick1  = ~halted & sel_tick(clock_select1_i, taps, rise1, fall1);
	assign timer0_tick_o = tick0;
	assign timer1_tick_o = tick1;

	assign icr_top = (core_i.waveform_mode == WGM_PFC_ICR) ||
		(core_i.waveform_mode == WGM_PC_ICR) ||
		(core_i.waveform_mode == WGM_CTC_ICR) ||
		(core_i.waveform_mode == WGM_FAST_ICR);
	assign ovf_plain = (core_i.waveform_mode == WGM_NORMAL) ||
		(core_i.waveform_mode == WGM_CTC_CMP) ||
		(core_i.waveform_mode == WGM_CTC_ICR);

	always_comb
	begin
		hw_set = 4'h0;
		// Capture pin is disconnected while the capture register is top
		if (icr_top)
			hw_set[F_CAP] = tick1 && (core_i.counter_value == core_i.capture_register);
		else
			hw_set[F_CAP] = capture_event_i;
		// Force strobes are deliberately not inputs to these terms
		hw_set[F_CMPB] = tick1 & st_q.pend_b;
		hw_set[F_CMPA] = tick1 & st_q.pend_a;
		// Other modes: the core reports its own overflow point
		if (ovf_plain)
			hw_set[F_OVF] = tick1 && (core_i.counter_value == COUNT_MAX);
		else
			hw_set[F_OVF] = overflow_event_i;
	end

	always_comb
	begin
		sw_clr = irq_ack_i;
		if (we_i && addr_i == FLAGS_OFF)
			sw_clr = sw_clr | unpack_bits(wdata_i);
	end

	assign flags_byte   = pack_bits(st_q.flags);
	assign enables_byte = pack_bits(st_q.enables);

	always_comb
	begin
		st_d = st_q;
		// Set has priority so no event is lost to a racing clear
		st_d.flags = (st_q.flags & ~sw_clr) | hw_set;
		if (tick1)
		begin
			st_d.pend_a = core_i.counter_value == core_i.compare_a_register;
			st_d.pend_b = core_i.counter_value == core_i.compare_b_register;
		end
		if (~st_q.sync_hold_mode)
			st_d.prescaler_reset = 1'b0;
		if (we_i && addr_i == ENABLES_OFF)
			st_d.enables = unpack_bits(wdata_i);
		if (we_i && addr_i == GCTRL_OFF)
		begin
			st_d.sync_hold_mode  = wdata_i[TSM_BIT];
			st_d.prescaler_reset = wdata_i[PSR_BIT];
		end
		st_d.rdata = 8'h00;
		if (re_i)
		begin
			unique case (addr_i)
				FLAGS_OFF:   st_d.rdata = flags_byte;
				ENABLES_OFF: st_d.rdata = enables_byte;
				GCTRL_OFF:
				begin
					st_d.rdata[TSM_BIT] = st_q.sync_hold_mode;
					st_d.rdata[PSR_BIT] = st_q.prescaler_reset;
				end
				default:     st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			st_q       <= '0;
			st_q.rdata <= REG_RESET;
		end
		else
			st_q <= st_d;
	end

	assign rdata_o = st_q.rdata;

	// Global flag is a live input so masking it acts at once
	assign irq_req_o[F_CAP]  = st_q.enables[F_CAP] & global_irq_enable_i & st_q.flags[F_CAP];
	assign irq_req_o[F_CMPB] = st_q.enables[F_CMPB] & global_irq_enable_i & st_q.flags[F_CMPB];
	assign irq_req_o[F_CMPA] = st_q.enables[F_CMPA] & global_irq_enable_i & st_q.flags[F_CMPA];
	assign irq_req_o[F_OVF]  = st_q.enables[F_OVF] & global_irq_enable_i & st_q.flags[F_OVF];

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_match_a;
		tick1 && core_i.counter_value == core_i.compare_a_register;
	endsequence

	sequence s_read_flags;
		re_i && addr_i == FLAGS_OFF;
	endsequence

	a_cmp_a_delay: assert property (s_match_a |=> st_q.pend_a)
		else $error("compare A match not armed");
	a_cmp_a_set: assert property (tick1 && st_q.pend_a |=> st_q.flags[F_CMPA])
		else $error("compare A flag not set on tick after match");
	a_set_wins: assert property ((hw_set[F_CMPB] && sw_clr[F_CMPB]) |=> st_q.flags[F_CMPB])
		else $error("clear beat a same-cycle set");
	a_reserved_read: assert property (s_read_flags |=> rdata_o[7:6] == 2'b00 && rdata_o[4:3] == 2'b00)
		else $error("reserved flag bits read nonzero");
	a_psr_autoclear: assert property (st_q.prescaler_reset && !st_q.sync_hold_mode
		&& !(we_i && addr_i == GCTRL_OFF) |=> !st_q.prescaler_reset)
		else $error("prescaler reset did not self clear");
	a_tsm_hold: assert property (st_q.prescaler_reset && st_q.sync_hold_mode
		&& !we_i |=> st_q.prescaler_reset && !timer1_tick_o)
		else $error("held prescaler reset released");
	a_div8_gap: assert property (clock_select1_i == CS_DIV8 && tick1 && !we_i
		|=> (!tick1)[*7])
		else $error("divide by 8 ticked early");
	a_ext_rise: assert property (clock_select1_i == CS_EXT_RISE && !halted
		&& $rose(external_timer_pin1_i) ##1 !$changed(clock_select1_i) |=> ##[0:1] tick1)
		else $error("external rising edge gave no tick");
	a_ovf_set: assert property (ovf_plain && tick1 && core_i.counter_value == COUNT_MAX
		|=> st_q.flags[F_OVF])
		else $error("overflow flag missing after wrap");
	a_cap_req: assert property (irq_req_o[F_CAP] |-> st_q.flags[F_CAP] && global_irq_enable_i
		&& $past(st_q.enables[F_CAP]) | st_q.enables[F_CAP])
		else $error("capture request without cause");
	a_cap_set: assert property (!icr_top && capture_event_i |=> st_q.flags[F_CAP])
		else $error("capture flag missed event");
endmodule : timer_prescaler_and_irq_flags
`default_nettype wire

// [ext_clk_source.sv]
// Behavioural external clock source for the timer input pins
`timescale 1ns/1ps
`default_nettype none
module ext_clk_source (
	input  wire logic       sys_clk_i,
	input  wire logic       run_i,
	input  wire logic [3:0] half_i,
	output logic            pin_o
);
	logic [3:0] cnt_q;
	initial
	begin
		pin_o = 1'b0;
		cnt_q = 4'h0;
	end
	// Half period counted in system clocks; caller keeps it above one
	always @(posedge sys_clk_i)
	begin
		if (!run_i)
			cnt_q <= 4'h0; // Pin stands still while stopped, so selects change on a stable pin
		else if (cnt_q == half_i - 4'h1)
		begin
			cnt_q <= 4'h0;
			pin_o <= ~pin_o;
		end
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : ext_clk_source
`default_nettype wire

// [tb_timer_prescaler_and_irq_flags.sv]
// Self-checking bench for the timer prescaler and timer1 flag block
`timescale 1ns/1ps
`default_nettype none
module tb_timer_prescaler_and_irq_flags;
	import timer_irq_pkg::*;
	logic         sys_clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic [5:0]   addr = 6'h00;
	logic [7:0]   wdata = 8'h00;
	logic         we = 1'b0;
	logic         re = 1'b0;
	logic [7:0]   rdata;
	logic [2:0]   cs0 = 3'h0;
	logic [2:0]   cs1 = 3'h1;
	logic         pin;
	logic         tick0;
	logic         tick1;
	timer1_core_t core = '{16'h0000, 16'h03E8, 16'h03E8, 16'h0BB8, 4'h0};
	logic         cap_ev = 1'b0;
	logic         ovf_ev = 1'b0;
	logic         frc_a = 1'b0;
	logic         frc_b = 1'b0;
	logic         gie = 1'b0;
	logic [3:0]   ack = 4'h0;
	logic [3:0]   req;
	logic         run = 1'b0;
	logic [2:0]   ph = 3'h0;
	int           error_cnt = 0;
	int           total_checks = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) ph <= {ph[1:0], pin};
	timer_prescaler_and_irq_flags i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr),
		.wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .clock_select0_i(cs0),
		.clock_select1_i(cs1), .external_timer_pin0_i(pin), .external_timer_pin1_i(pin),
		.timer0_tick_o(tick0), .timer1_tick_o(tick1), .core_i(core), .capture_event_i(cap_ev),
		.overflow_event_i(ovf_ev), .force_compare_a_i(frc_a), .force_compare_b_i(frc_b),
		.global_irq_enable_i(gie), .irq_ack_i(ack), .irq_req_o(req));
	// Six clocks per period keeps under the recommended external rate
	ext_clk_source i_src (.sys_clk_i(sys_clk_i), .run_i(run), .half_i(4'h3), .pin_o(pin));
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : step
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge sys_clk_i);
		we <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr <= a;
		re <= 1'b1;
		@(posedge sys_clk_i);
		re <= 1'b0;
		#1;
		chk("rdata", {8'h00, e}, {8'h00, rdata});
	endtask : rdchk
	task automatic count0(input int n, output logic [15:0] c);
		c = 16'h0000;
		repeat (n)
		begin
			@(posedge sys_clk_i);
			#1;
			c = c + {15'h0000, tick0};
		end
	endtask : count0
	task automatic t_regs;
		rdchk(FLAGS_OFF, 8'h00);
		rdchk(GCTRL_OFF, 8'h00);
		wr(ENABLES_OFF, 8'hFF);
		rdchk(ENABLES_OFF, 8'h27);
		wr(6'h3F, 8'hFF);
		rdchk(6'h3F, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_flags;
		gie <= 1'b1;
		@(posedge sys_clk_i);
		core.counter_value <= 16'hFFFF;
		cap_ev <= 1'b1;
		@(posedge sys_clk_i);
		core.counter_value <= 16'h03E8;
		cap_ev <= 1'b0;
		@(posedge sys_clk_i);
		core.counter_value <= 16'h03E9;
		rdchk(FLAGS_OFF, 8'h27);
		chk("irq", 16'h000F, {12'h000, req});
		gie <= 1'b0;
		step(1);
		chk("irq", 16'h0000, {12'h000, req});
		gie <= 1'b1;
		wr(ENABLES_OFF, 8'h02);
		step(1);
		chk("irq", 16'h0002, {12'h000, req});
		wr(ENABLES_OFF, 8'h27);
		wr(FLAGS_OFF, 8'hC9);
		rdchk(FLAGS_OFF, 8'h26);
		wr(FLAGS_OFF, 8'h00);
		rdchk(FLAGS_OFF, 8'h26);
		@(posedge sys_clk_i);
		ack <= 4'h8;
		@(posedge sys_clk_i);
		ack <= 4'h2;
		@(posedge sys_clk_i);
		ack <= 4'h0;
		rdchk(FLAGS_OFF, 8'h04);
		wr(FLAGS_OFF, 8'h04);
		rdchk(FLAGS_OFF, 8'h00);
		chk("irq", 16'h0000, {12'h000, req});
		$display("test flags done");
	endtask : t_flags
	task automatic t_force_race;
		@(posedge sys_clk_i);
		frc_a <= 1'b1;
		frc_b <= 1'b1;
		@(posedge sys_clk_i);
		frc_a <= 1'b0;
		frc_b <= 1'b0;
		step(3);
		rdchk(FLAGS_OFF, 8'h00);
		@(posedge sys_clk_i);
		addr <= FLAGS_OFF;
		wdata <= 8'h20;
		we <= 1'b1;
		cap_ev <= 1'b1;
		@(posedge sys_clk_i);
		we <= 1'b0;
		cap_ev <= 1'b0;
		rdchk(FLAGS_OFF, 8'h20);
		wr(FLAGS_OFF, 8'h20);
		$display("test force and race done");
	endtask : t_force_race
	task automatic t_modes;
		@(posedge sys_clk_i);
		core.waveform_mode <= WGM_CTC_ICR;
		core.capture_register <= 16'h0032;
		core.counter_value <= 16'h0032;
		@(posedge sys_clk_i);
		core.counter_value <= 16'h0033;
		rdchk(FLAGS_OFF, 8'h20);
		wr(FLAGS_OFF, 8'h20);
		@(posedge sys_clk_i);
		core.waveform_mode <= WGM_PFC_ICR;
		ovf_ev <= 1'b1;
		@(posedge sys_clk_i);
		ovf_ev <= 1'b0;
		rdchk(FLAGS_OFF, 8'h01);
		wr(FLAGS_OFF, 8'h01);
		core.waveform_mode <= WGM_NORMAL;
		$display("test modes done");
	endtask : t_modes
	task automatic t_presc;
		int          dv [6] = '{0, 1, 8, 64, 256, 1024};
		int          n;
		logic [15:0] c;
		for (int k = 0; k < 6; k++)
		begin
			@(posedge sys_clk_i);
			cs0 <= k[2:0];
			#1;
			n = 1;
			while (k > 0 && tick0 !== 1'b1 && n < 1100)
			begin
				step(1);
				n++;
			end
			if (k > 0)
				chk("first tick", 16'h0001, {15'h0000, n <= dv[k] + 1});
			count0(2048, c);
			chk("tick count", (k == 0) ? 16'h0000 : 16'(2048 / dv[k]), c);
		end
		$display("test prescaler done");
	endtask : t_presc
	task automatic t_psr;
		logic [15:0] c;
		cs0 <= 3'h1;
		wr(GCTRL_OFF, 8'h01);
		step(2);
		rdchk(GCTRL_OFF, 8'h00);
		wr(GCTRL_OFF, 8'h81);
		step(2);
		rdchk(GCTRL_OFF, 8'h81);
		count0(16, c);
		chk("held ticks", 16'h0000, c);
		wr(GCTRL_OFF, 8'h00);
		step(2);
		rdchk(GCTRL_OFF, 8'h00);
		count0(16, c);
		chk("resumed ticks", 16'h0010, c);
		$display("test prescaler reset done");
	endtask : t_psr
	task automatic t_ext;
		cs0 <= CS_EXT_FALL;
		cs1 <= CS_EXT_RISE;
		step(3);
		run <= 1'b1;
		repeat (80)
		begin
			step(1);
			chk("rise tick", {15'h0000, ph[1] & ~ph[2]}, {15'h0000, tick1});
			chk("fall tick", {15'h0000, ~ph[1] & ph[2]}, {15'h0000, tick0});
		end
		run <= 1'b0;
		step(4);
		cs1 <= CS_DIV1;
		$display("test external clock done");
	endtask : t_ext
	initial
	begin
		#9000000;
		error_cnt++;
		test_done();
	end
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_flags();
		t_force_race();
		t_modes();
		t_presc();
		t_psr();
		t_ext();
		test_done();
	end
endmodule : tb_timer_prescaler_and_irq_flags
`default_nettype wire
